// ==== rlm_pkg.sv ====
package rlm_pkg;
   // Register indices and byte addresses
   localparam logic [7:0]  IDX_GENERAL   = 8'h11;
   localparam logic [7:0]  IDX_TXMODE    = 8'h12;
   localparam logic [7:0]  IDX_RXMODE    = 8'h13;
   localparam logic [9:0]  ADDR_GENERAL  = {IDX_GENERAL, 2'b00};
   localparam logic [9:0]  ADDR_TXMODE   = {IDX_TXMODE, 2'b00};
   localparam logic [9:0]  ADDR_RXMODE   = {IDX_RXMODE, 2'b00};
   localparam logic [9:0]  ADDR_IRQSTAT  = 10'h080;
   localparam logic [9:0]  ADDR_IRQMASK  = 10'h084;
   localparam logic [9:0]  ADDR_STATUS   = 10'h088;
   // Reset values
   localparam logic [7:0]  RST_GENERAL   = 8'h3F;
   localparam logic [7:0]  RST_TXMODE    = 8'h00;
   localparam logic [7:0]  RST_RXMODE    = 8'h00;
   // Writable bits per register
   localparam logic [7:0]  MASK_GENERAL  = 8'hAB;
   localparam logic [7:0]  MASK_TXMODE   = 8'hF8;
   localparam logic [7:0]  MASK_RXMODE   = 8'hFC;
   // Field positions
   localparam int          BIT_CRC_BIT_ORDER_SEL  = 7;
   localparam int          BIT_WAITRF    = 5;
   localparam int          BIT_POL       = 3;
   localparam int          BIT_CRCEN     = 7;
   localparam int          BIT_MODULATION_INVERT    = 3;
   localparam int          BIT_NOERR     = 3;
   localparam int          BIT_MULTI     = 2;
   localparam int          SPD_LSB       = 4;
   // Interrupt bits
   localparam int          IRQ_ENV       = 0;
   localparam int          IRQ_TXBLOCK   = 1;
   localparam int          IRQ_SHORT     = 2;
   localparam int          IRQ_W         = 3;
   // CRC presets and minimum receive stream length
   localparam logic [15:0] PRESET_00     = 16'h0000;
   localparam logic [15:0] PRESET_01     = 16'h6363;
   localparam logic [15:0] PRESET_10     = 16'hA671;
   localparam logic [15:0] PRESET_11     = 16'hFFFF;
   localparam logic [2:0]  MIN_RX_BITS   = 3'h4;
   // Bit rates
   typedef enum logic [2:0] {RATE_106 = 3'h0, RATE_212 = 3'h1, RATE_424 = 3'h2,
                             RATE_848 = 3'h3, RATE_RSVD = 3'h7} rlm_rate_e;
   typedef enum logic [1:0] {RX_IDLE, RX_ACTIVE, RX_APPEND} rlm_rx_e;
endpackage

// ==== rlm_crc_preset.sv ====
`timescale 1ns/100ps
`default_nettype none
module rlm_crc_preset (
   input  wire logic [1:0]  presetSel,     // Software preset code
   input  wire logic        rfActive,      // RF communication in progress
   input  wire logic [15:0] autoPreset,    // Preset chosen from mode registers
   output logic      [15:0] crcPreset      // Preset to CRC coprocessor
);
   always_comb begin
      if (rfActive) begin
         crcPreset = autoPreset;
      end else begin
         case (presetSel)
            2'b00:   crcPreset = rlm_pkg::PRESET_00;
            2'b01:   crcPreset = rlm_pkg::PRESET_01;
            2'b10:   crcPreset = rlm_pkg::PRESET_10;
            default: crcPreset = rlm_pkg::PRESET_11;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== rlm_mode_regs.sv ====
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - With bit-order bit 7 set, the CRC unit runs MSB first and both result bytes are bit-reversed.
// - During RF communication the bit-order bit is ignored and the protocol order is used.
// - With wait-for-field bit 5 set, a transmission may not start unless the RF field is on.
// - Bit 3 picks the envelope pin level: 1 active high, 0 active low.
// - The internal envelope is active low and any change of bit 3 raises the envelope interrupt event.
// - For standalone CRC the preset code 00/01/10/11 loads 0000h/6363h/A671h/FFFFh.
// - During RF communication the CRC preset comes from the transmit and receive mode settings.
// - Transmit CRC enable bit 7 makes the device append a CRC to sent frames.
// - Transmit speed 000/001/010/011 selects 106/212/424/848 kBd; other codes are reserved.
// - Modulation invert bit 3 inverts the modulation of sent data.
// - Receive CRC enable bit 7 turns on CRC checking of received frames.
// - Receive speed 000/001/010/011 selects 106/212/424/848 kBd; other codes are reserved.
// - With bit 3 of the receive mode set, a stream of under 4 bits is dropped and the receiver stays on.
// - Multiple-receive bit 2 at 0 ends reception after one frame; at 1 reception keeps running.
// - With multiple receive on, an error byte copying the error register ends each received stream.
module rlm_mode_regs (
   input  wire logic        mclk,          // System clock
   input  wire logic        nrst,          // Async reset, active low
   input  wire logic [31:0] haddr,         // AHB address
   input  wire logic [1:0]  htrans,        // AHB transfer type
   input  wire logic        hwrite,        // AHB write
   input  wire logic [2:0]  hsize,         // AHB size
   input  wire logic        hsel,          // AHB select
   input  wire logic        hready,        // AHB ready in
   input  wire logic [31:0] hwdata,        // AHB write data
   output logic      [31:0] hrdata,        // AHB read data
   output logic             hreadyout,     // AHB ready out
   output logic             hresp,         // AHB response
   output logic             irq,           // Level interrupt
   input  wire logic        envelopeInPin, // Envelope input pin
   output logic             envelopeIntN,  // Internal envelope, active low
   input  wire logic        rfFieldOn,     // RF field generated
   input  wire logic        rfActive,      // RF communication running
   input  wire logic        txRequest,     // Transmitter start request
   output logic             txStart,       // Transmitter start granted
   output logic             txCrcEnable,   // Append CRC on transmit
   output logic             modInvert,     // Invert transmit modulation
   output logic      [2:0]  txRate,        // Transmit rate code, reserved mapped
   output logic             rxCrcEnable,   // Check CRC on receive
   output logic      [2:0]  rxRate,        // Receive rate code, reserved mapped
   input  wire logic        rxFrameEnd,    // Received stream ended
   input  wire logic [5:0]  rxBitCount,    // Bits in the ended stream, saturating
   input  wire logic [7:0]  errorFlags,    // Current error register
   output logic             rxEnable,      // Receiver active
   output logic             rxDiscard,     // Drop ended short stream
   output logic             fifoWrite,     // Push error byte into FIFO
   output logic      [7:0]  fifoData,      // Error byte
   input  wire logic        crcStart,      // Start receive/standalone CRC, arms receiver only while rfActive
   output logic             crcMsbFirst,   // CRC unit runs MSB first
   output logic             crcReverse,    // Reverse both result bytes
   output logic      [15:0] crcPreset      // CRC preset value
);
   // Reset synchroniser
   logic             rstMeta_r;
   logic             rstSync_r;
   // Mode registers
   logic [7:0]       gen_r;
   logic [7:0]       gen_nxt;
   logic [7:0]       tx_r;
   logic [7:0]       tx_nxt;
   logic [7:0]       rx_r;
   logic [7:0]       rx_nxt;
   // Interrupt status and mask
   logic [2:0]       ist_r;
   logic [2:0]       ist_nxt;
   logic [2:0]       imk_r;
   logic [2:0]       imk_nxt;
   logic [2:0]       ev;
   // Bus data phase
   logic             aWr_r;
   logic             aWr_nxt;
   logic [9:0]       aAdr_r;
   logic [9:0]       aAdr_nxt;
   logic [31:0]      rdat_r;
   logic [31:0]      rdat_nxt;
   logic             accept;
   logic             wrGen;
   logic             wrTx;
   logic             wrRx;
   logic             wrMask;
   logic             wrStat;
   logic [4:0]       statusWord;
   // Receiver
   logic [7:0]       fdat_r;
   logic [7:0]       fdat_nxt;
   logic             fwr_r;
   logic             fwr_nxt;
   logic             shortFrame;
   logic [15:0]      autoPreset;
   rlm_pkg::rlm_rx_e rxSt_r;
   rlm_pkg::rlm_rx_e rxSt_nxt;

   function automatic logic [2:0] mapRate(input logic [2:0] code);
      mapRate = (code > rlm_pkg::RATE_848) ? rlm_pkg::RATE_RSVD : code;
   endfunction

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   assign accept     = hsel && hready && htrans[1];
   assign shortFrame = rxFrameEnd && (rxBitCount < {3'h0, rlm_pkg::MIN_RX_BITS});

   // Write strobes of the data phase, one per writable register
   assign wrGen      = aWr_r && (aAdr_r == rlm_pkg::ADDR_GENERAL);
   assign wrTx       = aWr_r && (aAdr_r == rlm_pkg::ADDR_TXMODE);
   assign wrRx       = aWr_r && (aAdr_r == rlm_pkg::ADDR_RXMODE);
   assign wrMask     = aWr_r && (aAdr_r == rlm_pkg::ADDR_IRQMASK);
   assign wrStat     = aWr_r && (aAdr_r == rlm_pkg::ADDR_IRQSTAT);
   assign statusWord = {rfFieldOn, rfActive, rxEnable, envelopeIntN, 1'b0};

   // Mode registers; reserved bits never store
   always_comb begin
      gen_nxt = gen_r;
      tx_nxt  = tx_r;
      rx_nxt  = rx_r;
      if (wrGen) begin
         gen_nxt = hwdata[7:0] & rlm_pkg::MASK_GENERAL;
      end
      if (wrTx) begin
         tx_nxt = hwdata[7:0] & rlm_pkg::MASK_TXMODE;
      end
      if (wrRx) begin
         rx_nxt = hwdata[7:0] & rlm_pkg::MASK_RXMODE;
      end
   end

   always_ff @(posedge mclk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         gen_r <= rlm_pkg::RST_GENERAL & rlm_pkg::MASK_GENERAL;
         tx_r  <= rlm_pkg::RST_TXMODE;
         rx_r  <= rlm_pkg::RST_RXMODE;
      end else begin
         gen_r <= gen_nxt;
         tx_r  <= tx_nxt;
         rx_r  <= rx_nxt;
      end
   end

   // Interrupts: an event in the cycle of a write-one clear wins
   always_comb begin
      imk_nxt = imk_r;
      if (wrMask) begin
         imk_nxt = hwdata[2:0];
      end
      ev                       = 3'h0;
      ev[rlm_pkg::IRQ_ENV]     = gen_nxt[rlm_pkg::BIT_POL] != gen_r[rlm_pkg::BIT_POL];
      ev[rlm_pkg::IRQ_TXBLOCK] = txRequest && !txStart;
      ev[rlm_pkg::IRQ_SHORT]   = shortFrame && rx_r[rlm_pkg::BIT_NOERR];
      ist_nxt = ist_r;
      if (wrStat) begin
         ist_nxt = ist_r & ~hwdata[2:0];
      end
      ist_nxt = ist_nxt | ev;
   end

   always_ff @(posedge mclk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         ist_r <= 3'h0;
         imk_r <= 3'h0;
      end else begin
         ist_r <= ist_nxt;
         imk_r <= imk_nxt;
      end
   end

   // Bus: address phase captured, read data registered for the data phase
   always_comb begin
      aWr_nxt  = accept && hwrite;
      aAdr_nxt = accept ? haddr[9:0] : aAdr_r;
      rdat_nxt = 32'h0000_0000;
      if (accept && !hwrite) begin
         case (haddr[9:0])
            rlm_pkg::ADDR_GENERAL: rdat_nxt = {24'h0, gen_nxt};
            rlm_pkg::ADDR_TXMODE:  rdat_nxt = {24'h0, tx_nxt};
            rlm_pkg::ADDR_RXMODE:  rdat_nxt = {24'h0, rx_nxt};
            rlm_pkg::ADDR_IRQSTAT: rdat_nxt = {29'h0, ist_nxt};
            rlm_pkg::ADDR_IRQMASK: rdat_nxt = {29'h0, imk_nxt};
            rlm_pkg::ADDR_STATUS:  rdat_nxt = {27'h0, statusWord};
            default:               rdat_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         aWr_r  <= 1'b0;
         aAdr_r <= 10'h000;
         rdat_r <= 32'h0000_0000;
      end else begin
         aWr_r  <= aWr_nxt;
         aAdr_r <= aAdr_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign hrdata    = rdat_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = |(ist_r & imk_r);

   // Envelope: normalise to active low
   assign envelopeIntN = gen_r[rlm_pkg::BIT_POL] ? ~envelopeInPin : envelopeInPin;
   assign txStart      = txRequest && (!gen_r[rlm_pkg::BIT_WAITRF] || rfFieldOn);
   assign txCrcEnable  = tx_r[rlm_pkg::BIT_CRCEN];
   assign modInvert    = tx_r[rlm_pkg::BIT_MODULATION_INVERT];
   assign txRate       = mapRate(tx_r[rlm_pkg::SPD_LSB +: 3]);
   assign rxCrcEnable  = rx_r[rlm_pkg::BIT_CRCEN];
   assign rxRate       = mapRate(rx_r[rlm_pkg::SPD_LSB +: 3]);
   assign crcMsbFirst  = gen_r[rlm_pkg::BIT_CRC_BIT_ORDER_SEL] && !rfActive;
   assign crcReverse   = crcMsbFirst;
   assign autoPreset   = (txCrcEnable || rxCrcEnable) ? rlm_pkg::PRESET_01 : rlm_pkg::PRESET_00;

   rlm_crc_preset uPreset (
      .presetSel  (gen_r[1:0]),
      .rfActive   (rfActive),
      .autoPreset (autoPreset),
      .crcPreset  (crcPreset)
   );

   // Receiver activity and error-byte append
   always_comb begin
      rxSt_nxt = rxSt_r;
      fwr_nxt  = 1'b0;
      fdat_nxt = fdat_r;
      case (rxSt_r)
         rlm_pkg::RX_IDLE: begin
            if (crcStart && rfActive) begin
               rxSt_nxt = rlm_pkg::RX_ACTIVE;
            end
         end
         rlm_pkg::RX_ACTIVE: begin
            if (!rfActive) begin
               rxSt_nxt = rlm_pkg::RX_IDLE;
            end else if (rxFrameEnd && !(shortFrame && rx_r[rlm_pkg::BIT_NOERR])) begin
               if (rx_r[rlm_pkg::BIT_MULTI]) begin
                  rxSt_nxt = rlm_pkg::RX_APPEND;
               end else begin
                  rxSt_nxt = rlm_pkg::RX_IDLE;
               end
            end
         end
         rlm_pkg::RX_APPEND: begin
            fwr_nxt  = 1'b1;
            fdat_nxt = errorFlags;
            rxSt_nxt = rlm_pkg::RX_ACTIVE;
         end
         default: rxSt_nxt = rlm_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         rxSt_r <= rlm_pkg::RX_IDLE;
         fwr_r  <= 1'b0;
         fdat_r <= 8'h00;
      end else begin
         rxSt_r <= rxSt_nxt;
         fwr_r  <= fwr_nxt;
         fdat_r <= fdat_nxt;
      end
   end

   assign rxEnable  = rxSt_r != rlm_pkg::RX_IDLE;
   assign rxDiscard = shortFrame && rx_r[rlm_pkg::BIT_NOERR];
   assign fifoWrite = fwr_r;
   assign fifoData  = fdat_r;
endmodule
`default_nettype wire

// ==== rlm_mode_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module rlm_mode_checker (
   input wire logic        mclk,        // Clock
   input wire logic        nrst,        // Reset
   input wire logic        hreadyout,   // Ready
   input wire logic        hresp,       // Response
   input wire logic        rfFieldOn,   // Field on
   input wire logic        rfActive,    // RF busy
   input wire logic        txRequest,   // Tx ask
   input wire logic        txStart,     // Tx go
   input wire logic        crcMsbFirst, // Order
   input wire logic        crcReverse,  // Reverse
   input wire logic [15:0] crcPreset,   // Preset
   input wire logic [2:0]  txRate,      // Tx rate
   input wire logic [2:0]  rxRate,      // Rx rate
   input wire logic        rxFrameEnd,  // Frame end
   input wire logic [5:0]  rxBitCount,  // Bits
   input wire logic [7:0]  errorFlags,  // Errors
   input wire logic        rxEnable,    // Rx on
   input wire logic        rxDiscard,   // Drop
   input wire logic        fifoWrite,   // Push
   input wire logic [7:0]  fifoData     // Byte
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_short_end;
      rxFrameEnd && rxEnable && rfActive && rxDiscard;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
   a_tx_gate: assert property (txStart |-> txRequest) else $error("tx start unasked");
   a_tx_block: assert property (txRequest && !txStart |-> !rfFieldOn) else $error("tx held in field");
   a_crc_pair: assert property (crcReverse == crcMsbFirst) else $error("reverse differs");
   a_crc_rf: assert property (rfActive |-> !crcMsbFirst) else $error("msb first in rf");
   a_preset_rf: assert property (rfActive |-> crcPreset inside {16'h0000, 16'h6363}) else $error("rf preset");
   a_preset_table: assert property (!rfActive |-> crcPreset inside {16'h0000, 16'h6363, 16'hA671, 16'hFFFF})
      else $error("preset value");
   a_rate_map: assert property (txRate inside {[3'h0:3'h3], 3'h7} && rxRate inside {[3'h0:3'h3], 3'h7})
      else $error("rate code");
   a_short_drop: assert property (rxDiscard |-> rxFrameEnd && rxBitCount < 6'h04) else $error("bad drop");
   a_short_stay: assert property (s_short_end |=> rxEnable) else $error("rx off after drop");
   a_error_byte: assert property (fifoWrite |-> $past(rxFrameEnd) || $past(rxFrameEnd, 2)) else $error("byte");
endmodule
bind rlm_mode_regs rlm_mode_checker u_chk (.mclk, .nrst, .hreadyout, .hresp, .rfFieldOn, .rfActive, .txRequest,
   .txStart, .crcMsbFirst, .crcReverse, .crcPreset, .txRate, .rxRate, .rxFrameEnd, .rxBitCount, .errorFlags,
   .rxEnable, .rxDiscard, .fifoWrite, .fifoData);
`default_nettype wire

// ==== test_rf_link_mode_config.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module test_rf_link_mode_config;
   localparam logic [9:0] GN = rlm_pkg::ADDR_GENERAL, TX = rlm_pkg::ADDR_TXMODE, RX = rlm_pkg::ADDR_RXMODE;
   localparam logic [9:0] ST = rlm_pkg::ADDR_IRQSTAT, MK = rlm_pkg::ADDR_IRQMASK;
   logic mclk, nrst, hwrite, hsel, hready, envelopeInPin, rfFieldOn, rfActive, txRequest, rxFrameEnd, crcStart;
   logic hreadyout, hresp, irq, envelopeIntN, txStart, txCrcEnable, modInvert, rxCrcEnable, rxEnable;
   logic rxDiscard, fifoWrite, crcMsbFirst, crcReverse;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, txRate, rxRate;
   logic [5:0]  rxBitCount;
   logic [7:0]  errorFlags, fifoData, fd;
   logic [15:0] crcPreset;
   logic [15:0] pv[4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
   int          n_fail = 0;
   int          compares = 0;
   rlm_mode_regs DUT (.mclk, .nrst, .haddr, .htrans, .hwrite, .hsize, .hsel, .hready, .hwdata, .hrdata,
      .hreadyout, .hresp, .irq, .envelopeInPin, .envelopeIntN, .rfFieldOn, .rfActive, .txRequest, .txStart,
      .txCrcEnable, .modInvert, .txRate, .rxCrcEnable, .rxRate, .rxFrameEnd, .rxBitCount, .errorFlags,
      .rxEnable, .rxDiscard, .fifoWrite, .fifoData, .crcStart, .crcMsbFirst, .crcReverse, .crcPreset);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic finish_test;
      if (n_fail == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Holds the current phase until hreadyout is seen high at a falling edge, then steps to the next rising edge
   task automatic wrdy;
      int  n;
      logic ok;
      n = 0;
      do begin
         @(negedge mclk);
         rd = hrdata;
         ok = hreadyout;
         @(posedge mclk);
         n++;
      end while (ok !== 1'b1 && n < 20);
      if (ok !== 1'b1) begin
         n_fail++;
         finish_test();
      end
   endtask
   task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      haddr <= {22'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsel <= 1'b1;
      wrdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wrdy();
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rdchk(input string nm, input logic [9:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      `CHK(nm, {24'h0, e}, rd)
   endtask
   task automatic t_regs;
      rdchk("gen rst", GN, 8'h2B);
      rdchk("tx rst", TX, 8'h00);
      rdchk("rx rst", RX, 8'h00);
      wr(GN, 8'hFF); rdchk("gen bits", GN, 8'hAB);
      wr(TX, 8'hFF); rdchk("tx bits", TX, 8'hF8);
      wr(RX, 8'hFF); rdchk("rx bits", RX, 8'hFC);
      wr(10'h040, 8'hFF); rdchk("unmapped", 10'h040, 8'h00);
   endtask
   task automatic t_irq;
      wr(ST, 8'h07); wr(MK, 8'h01); wr(GN, 8'hA3);
      rdchk("env event", ST, 8'h01);
      `CHK("irq on", 1'b1, irq)
      envelopeInPin <= 1'b1;
      @(negedge mclk); `CHK("env low pol", 1'b1, envelopeIntN)
      wr(MK, 8'h00); @(negedge mclk); `CHK("irq masked", 1'b0, irq)
      wr(MK, 8'h01); wr(ST, 8'h01); rdchk("env clear", ST, 8'h00);
      `CHK("irq off", 1'b0, irq)
      wr(GN, 8'hAB); @(negedge mclk); `CHK("env high pol", 1'b0, envelopeIntN)
   endtask
   task automatic t_tx;
      @(posedge mclk); txRequest <= 1'b1;
      @(negedge mclk); `CHK("tx no field", 1'b0, txStart)
      @(posedge mclk); rfFieldOn <= 1'b1;
      @(negedge mclk); `CHK("tx field", 1'b1, txStart)
      wr(GN, 8'h8B); rfFieldOn <= 1'b0;
      @(negedge mclk); `CHK("tx no wait", 1'b1, txStart)
      for (int c = 0; c < 8; c++) begin
         wr(TX, {1'b1, c[2:0], 4'h8}); wr(RX, {1'b1, c[2:0], 4'h0}); @(negedge mclk);
         `CHK("tx rate", (c < 4) ? c[2:0] : 3'h7, txRate)
         `CHK("rx rate", (c < 4) ? c[2:0] : 3'h7, rxRate)
         `CHK("tx crc", 1'b1, txCrcEnable)
         `CHK("mod inv", 1'b1, modInvert)
         `CHK("rx crc", 1'b1, rxCrcEnable)
      end
   endtask
   task automatic t_crc;
      for (int p = 0; p < 4; p++) begin
         wr(GN, 8'h80 | {6'h0, p[1:0]}); rfActive <= 1'b0;
         @(negedge mclk); `CHK("preset", pv[p], crcPreset)
         `CHK("msb first", 1'b1, crcMsbFirst)
         `CHK("reversed", 1'b1, crcReverse)
         @(posedge mclk); rfActive <= 1'b1;
         @(negedge mclk); `CHK("rf preset", 16'h6363, crcPreset)
         `CHK("rf order", 1'b0, crcMsbFirst)
      end
   endtask
   task automatic t_rx;
      int cnt;
      cnt = 0;
      wr(RX, 8'h0C); crcStart <= 1'b1;
      @(posedge mclk); crcStart <= 1'b0;
      @(negedge mclk); `CHK("rx armed", 1'b1, rxEnable)
      @(posedge mclk); rxFrameEnd <= 1'b1; rxBitCount <= 6'h03;
      @(negedge mclk); `CHK("short drop", 1'b1, rxDiscard)
      @(posedge mclk); rxBitCount <= 6'h04; errorFlags <= 8'h5A;
      @(negedge mclk); `CHK("four kept", 1'b0, rxDiscard)
      @(posedge mclk); rxFrameEnd <= 1'b0;
      repeat (3) begin
         @(negedge mclk);
         if (fifoWrite === 1'b1) begin
            cnt++;
            fd = fifoData;
         end
      end
      `CHK("error byte", 8'h5A, fd)
      `CHK("byte count", 1, cnt)
      `CHK("multi on", 1'b1, rxEnable)
      wr(RX, 8'h00); rxFrameEnd <= 1'b1;
      @(posedge mclk); rxFrameEnd <= 1'b0;
      @(negedge mclk); `CHK("single frame", 1'b0, rxEnable)
   endtask
   initial begin
      {nrst, hsel, hwrite, htrans, haddr, hwdata, envelopeInPin, rfFieldOn, rfActive} = '0;
      {txRequest, rxFrameEnd, crcStart, rxBitCount, errorFlags, fd} = '0;
      hready = 1'b1;
      hsize = 3'h2;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      t_regs();
      t_irq();
      t_tx();
      t_crc();
      t_rx();
      finish_test();
   end
endmodule
`default_nettype wire
